/* File: common/sdw_pkg.sv */
// Shared constants and types for the SDRAM write-termination core
package sdw_pkg;
	// Clock period and recovery figures in nanoseconds
	localparam int CLK_NS = 10;
	localparam int WR_NS = 15; // write_recovery_time
	localparam int RP_NS = 20; // precharge_period
	// Least times round up; never below one cycle
	localparam int WR_RAW = (WR_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_RAW = (RP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] WR_CNT = 4'((WR_RAW < 1) ? 1 : WR_RAW);
	localparam logic [3:0] RP_CNT = 4'((RP_RAW < 1) ? 1 : RP_RAW);
	// Geometry of the modelled array
	localparam int COL_W = 3;
	localparam int AP_BIT = 10; // auto_precharge_select_bit
	// APB register byte offsets
	localparam logic [11:0] MODE_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam logic [11:0] ERR_OFF = 12'h008;
	localparam logic [11:0] WCNT_OFF = 12'h00c;
	// Mode register fields and reset value (burst of four, latency two)
	localparam int BL_LSB = 0;
	localparam int CL_LSB = 4;
	localparam int WBM_BIT = 9; // write_burst_mode_bit
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [31:0] MODE_RST = 32'h0000_0022;
	// Error flag positions
	localparam int ERR_CLOSED = 0;
	localparam int ERR_BUSY = 1;
	localparam int ERR_EARLY = 2;
	// Command encodings {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SDW_ACT = 4'b0011,
		SDW_PRE = 4'b0010,
		SDW_RD = 4'b0101,
		SDW_WR = 4'b0100,
		SDW_BST = 4'b0110,
		SDW_NOP = 4'b0111
	} sdw_cmd_t;
	// State of one running burst
	typedef struct packed {
		logic act;
		logic [1:0] bank;
		logic [COL_W-1:0] col;
		logic [3:0] left;
		logic ap;
		logic full;
	} sdw_burst_t;
endpackage

/* File: common/sdw_rd_if.sv */
// Read-data pipeline carrier between core and latency stage
`timescale 1ns/1ns
interface sdw_rd_if;
	logic push; // Element fetched this edge
	logic [31:0] data; // Fetched element
	logic [1:0] cl; // CAS latency, 1..3
	logic vld; // Output element valid
	logic [31:0] q; // Output element
	modport core (output push, output data, output cl, input vld, input q);
	modport pipe (input push, input data, input cl, output vld, output q);
endinterface

/* File: rtl/sdw_bank.sv */
// Per-bank row, write recovery and precharge tracker
`timescale 1ns/1ns
module sdw_bank (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic act_go,
	input wire logic pre_go,
	input wire logic rec_go,
	input wire logic wstore,
	output logic open,
	output logic busy,
	output logic guard
);
	logic open_r; // Row open
	logic [3:0] rec_r; // Auto precharge write recovery
	logic [3:0] rp_r; // Precharge period remaining
	logic [3:0] wg_r; // Recovery since last stored data
	wire rec_fire = (rec_r == 4'h1); // Recovery done, close now
	wire pre_start = (pre_go & open_r) | rec_fire;
	// Bank state; a precharge to an idle bank is a no-op
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_r <= 1'b0;
			rec_r <= 4'h0;
			rp_r <= 4'h0;
			wg_r <= 4'h0;
		end else begin
			open_r <= act_go | (open_r & ~pre_start);
			rec_r <= rec_go ? sdw_pkg::WR_CNT : rec_r - {3'h0, |rec_r};
			rp_r <= pre_start ? sdw_pkg::RP_CNT : rp_r - {3'h0, |rp_r};
			// Loaded one short: a PRECHARGE exactly WR_CNT edges after the data is legal
			wg_r <= wstore ? (sdw_pkg::WR_CNT - 4'h1) : wg_r - {3'h0, |wg_r};
		end
	end
	assign open = open_r & ~(|rec_r);
	// Busy until the row is really closed and the precharge has run out
	assign busy = (|rp_r) | (|rec_r);
	assign guard = |wg_r;
endmodule

/* File: rtl/sdw_rdpipe.sv */
// CAS latency delay line for read data
`timescale 1ns/1ns
module sdw_rdpipe (
	input wire logic clk,
	input wire logic rst_n,
	sdw_rd_if.pipe rp
);
	logic [2:0] v_r; // Stage valid, stage 0 is the output
	logic [31:0] d_r [0:2]; // Stage data
	// Elements enter at stage cl-1 and walk towards stage 0.
	// Changing the latency with data in flight may collide stages.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			v_r <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				d_r[i] <= 32'h0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (rp.push && (2'(i) == rp.cl - 2'h1)) begin
					v_r[i] <= 1'b1;
					d_r[i] <= rp.data;
				end else if (i < 2) begin
					v_r[i] <= v_r[i+1];
					d_r[i] <= d_r[i+1];
				end else begin
					v_r[i] <= 1'b0;
				end
			end
		end
	end
	assign rp.vld = v_r[0];
	assign rp.q = d_r[0];
endmodule

/* File: rtl/sdw_dev.sv */
// SDRAM device core: write bursts, termination and precharge
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module sdw_dev (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic bank_select_low,
	input wire logic bank_select_high,
	input wire logic [11:0] addr,
	input wire logic [31:0] dq_in,
	input wire logic [3:0] dqm,
	output logic [31:0] dq_out,
	output logic dq_oe_n
);
	sdw_rd_if rdi ();
	// Register file
	logic [31:0] mode_r; // Burst length, latency, write mode
	logic [2:0] err_r; // Sticky command errors
	logic [15:0] wcnt_r; // Stored write elements
	logic [31:0] prdata_r; // Read data, captured in setup
	// Burst trackers
	sdw_pkg::sdw_burst_t wr_r, wr_nxt;
	sdw_pkg::sdw_burst_t rd_r, rd_nxt;
	// Storage: one row per bank, addressed by {bank, column}
	logic [31:0] mem_r [0:(4<<sdw_pkg::COL_W)-1];
	// Per-bank tracker outputs and controls
	logic [3:0] bank_open, bank_busy, bank_guard;
	logic [3:0] act_go, pre_go, rec_go, st_go;

	// APB decode; zero wait states
	wire apb_setup = psel & ~penable;
	wire apb_wr = psel & penable & pwrite;
	wire sel_mode = (paddr == sdw_pkg::MODE_OFF);
	wire sel_stat = (paddr == sdw_pkg::STAT_OFF);
	wire sel_err = (paddr == sdw_pkg::ERR_OFF);
	wire sel_wcnt = (paddr == sdw_pkg::WCNT_OFF);
	wire apb_hit = sel_mode | sel_stat | sel_err | sel_wcnt;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~apb_hit;
	assign prdata = prdata_r;
	wire [31:0] stat_w = {22'h0, rd_r.act, wr_r.act, bank_busy, bank_open};
	wire [31:0] rsel_w = sel_mode ? mode_r :
		sel_stat ? stat_w :
		sel_err ? {29'h0, err_r} :
		sel_wcnt ? {16'h0, wcnt_r} : 32'h0;

	// Mode fields
	wire [2:0] bl_code = mode_r[sdw_pkg::BL_LSB +: 3];
	wire full_pg = (bl_code == sdw_pkg::BL_FULL);
	wire [3:0] bl_len = 4'h1 << bl_code[1:0];
	wire wbm = mode_r[sdw_pkg::WBM_BIT];
	wire [1:0] cl_raw = mode_r[sdw_pkg::CL_LSB +: 2];
	// Single writes when the write burst mode bit is set, unless page mode overrides it
	wire [3:0] wr_len = (wbm & ~full_pg) ? 4'h1 : bl_len;
	wire [3:0] rd_len = bl_len;

	// Command decode, pins sampled on the rising edge
	wire [3:0] cmd_w = {cs_n, ras_n, cas_n, we_n};
	wire [1:0] ba = {bank_select_high, bank_select_low};
	wire ap = addr[sdw_pkg::AP_BIT];
	wire [sdw_pkg::COL_W-1:0] col = addr[sdw_pkg::COL_W-1:0];
	wire is_act = (cmd_w == sdw_pkg::SDW_ACT);
	wire is_pre = (cmd_w == sdw_pkg::SDW_PRE);
	wire is_rd = (cmd_w == sdw_pkg::SDW_RD);
	wire is_wr = (cmd_w == sdw_pkg::SDW_WR);
	wire is_bst = (cmd_w == sdw_pkg::SDW_BST);
	// Legality against the bank trackers; illegal READ, WRITE and ACTIVE are dropped, an early PRECHARGE still runs
	wire tgt_ok = bank_open[ba] & ~bank_busy[ba];
	wire rd_ok = is_rd & tgt_ok;
	wire wr_ok = is_wr & tgt_ok;
	wire act_ok = is_act & ~bank_open[ba] & ~bank_busy[ba];
	wire bad_closed = (is_rd | is_wr) & ~bank_open[ba];
	wire bad_busy = (is_rd | is_wr | is_act) & bank_busy[ba];
	// All banks when the select bit is high, else the addressed one
	wire [3:0] pre_sel = is_pre ? (ap ? 4'hf : 4'h1 << ba) : 4'h0;
	wire bad_early = |(pre_sel & bank_guard & bank_open);
	// Auto precharge only for fixed-length bursts
	wire eff_ap = ap & ~full_pg;

	// Write burst: stopped by READ, WRITE, terminate or same-bank PRECHARGE
	wire wr_stop = rd_ok | wr_ok | is_bst | pre_sel[wr_r.bank];
	wire wr_cont = wr_r.act & ~wr_stop;
	wire wr_last = wr_cont & ~wr_r.full & (wr_r.left == 4'h1);
	wire store = wr_ok | wr_cont;
	wire [1:0] st_bank = wr_ok ? ba : wr_r.bank;
	wire [sdw_pkg::COL_W-1:0] st_col = wr_ok ? col : wr_r.col;
	// Other-bank access interrupting a write with auto precharge
	wire wr_intr = wr_r.act & wr_r.ap & (rd_ok | wr_ok) & (ba != wr_r.bank);
	wire [3:0] wr_rec_bank = 4'h1 << wr_r.bank;
	wire [3:0] new_bank = 4'h1 << ba;
	// Recovery starts at the last stored element or at the interrupt
	assign rec_go = ((wr_ok & eff_ap & ~full_pg & (wr_len == 4'h1)) ? new_bank : 4'h0)
		| (((wr_last & wr_r.ap) | wr_intr) ? wr_rec_bank : 4'h0);
	// Fully masked edges are not wanted data and leave the recovery guard alone
	assign st_go = (store & ~(&dqm)) ? (4'h1 << st_bank) : 4'h0;
	assign act_go = act_ok ? new_bank : 4'h0;

	// Read burst
	wire rd_stop = rd_ok | wr_ok | is_bst | pre_sel[rd_r.bank];
	wire rd_cont = rd_r.act & ~rd_stop;
	wire rd_last = rd_cont & ~rd_r.full & (rd_r.left == 4'h1);
	wire fetch = rd_ok | rd_cont;
	wire [1:0] f_bank = rd_ok ? ba : rd_r.bank;
	wire [sdw_pkg::COL_W-1:0] f_col = rd_ok ? col : rd_r.col;
	// Other-bank access ends a read with auto precharge at once
	wire rd_intr = rd_r.act & rd_r.ap & (rd_ok | wr_ok) & (ba != rd_r.bank);
	wire [3:0] rd_pre_bank = 4'h1 << rd_r.bank;
	assign pre_go = pre_sel
		| ((rd_ok & eff_ap & (rd_len == 4'h1)) ? new_bank : 4'h0)
		| (((rd_last & rd_r.ap) | rd_intr) ? rd_pre_bank : 4'h0);

	// Next burst states
	always_comb begin
		wr_nxt = wr_r;
		if (wr_ok) begin
			wr_nxt.act = full_pg | (wr_len != 4'h1);
			wr_nxt.bank = ba;
			wr_nxt.left = wr_len - 4'h1;
			wr_nxt.ap = eff_ap;
			wr_nxt.full = full_pg;
		end else if (wr_cont) begin
			wr_nxt.act = ~wr_last;
			wr_nxt.left = wr_r.left - {3'h0, ~wr_r.full};
		end else begin
			wr_nxt.act = 1'b0;
		end
		wr_nxt.col = store ? st_col + 1'b1 : wr_r.col;
	end
	always_comb begin
		rd_nxt = rd_r;
		if (rd_ok) begin
			rd_nxt.act = full_pg | (rd_len != 4'h1);
			rd_nxt.bank = ba;
			rd_nxt.left = rd_len - 4'h1;
			rd_nxt.ap = eff_ap;
			rd_nxt.full = full_pg;
		end else if (rd_cont) begin
			rd_nxt.act = ~rd_last;
			rd_nxt.left = rd_r.left - {3'h0, ~rd_r.full};
		end else begin
			rd_nxt.act = 1'b0;
		end
		rd_nxt.col = fetch ? f_col + 1'b1 : rd_r.col;
	end

	// Error flags: a new event wins over a same-cycle clear
	wire [2:0] err_set = {bad_early, bad_busy, bad_closed & ~bad_busy};
	wire [2:0] err_clr = (apb_wr & sel_err) ? pwdata[2:0] : 3'h0;

	// Registers and bursts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= sdw_pkg::MODE_RST;
			err_r <= 3'h0;
			wcnt_r <= 16'h0;
			prdata_r <= 32'h0;
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (apb_wr & sel_mode) begin
				mode_r <= pwdata;
			end
			err_r <= (err_r & ~err_clr) | err_set;
			wcnt_r <= wcnt_r + {15'h0, store};
			prdata_r <= apb_setup ? rsel_w : prdata_r;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// Array write with byte mask; no reset on storage
	always_ff @(posedge pclk) begin
		if (store) begin
			for (int b = 0; b < 4; b++) begin
				if (!dqm[b]) begin
					mem_r[{st_bank, st_col}][b*8 +: 8] <= dq_in[b*8 +: 8];
				end
			end
		end
	end

	// Bank trackers
	for (genvar g = 0; g < 4; g++) begin : g_bank
		sdw_bank u_bank (
			.clk(pclk),
			.rst_n(presetn),
			.act_go(act_go[g]),
			.pre_go(pre_go[g]),
			.rec_go(rec_go[g]),
			.wstore(st_go[g]),
			.open(bank_open[g]),
			.busy(bank_busy[g]),
			.guard(bank_guard[g])
		);
	end

	// Read data after CAS latency; zero latency runs as one
	assign rdi.push = fetch;
	assign rdi.data = mem_r[{f_bank, f_col}];
	assign rdi.cl = (cl_raw == 2'h0) ? 2'h1 : cl_raw;
	sdw_rdpipe u_pipe (
		.clk(pclk),
		.rst_n(presetn),
		.rp(rdi.pipe)
	);
	assign dq_out = rdi.q;
	assign dq_oe_n = ~rdi.vld;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_read_ends_write: assert property (
		wr_r.act & rd_ok |-> ~store ##1 ~wr_r.act | rd_r.act)
		else $error("write burst kept storing after READ");
	chk_pre_cuts_write: assert property (
		wr_r.act & pre_sel[wr_r.bank] |-> ~store ##1 ~wr_r.act)
		else $error("PRECHARGE did not end write burst");
	chk_rec_min_one: assert property (
		rec_go[0] |=> bank_busy[0] [*1] ##0 ~bank_open[0])
		else $error("auto precharge recovery shorter than a clock");
	chk_bst_drops_data: assert property (
		is_bst & ~wr_ok |-> ~store ##1 ~wr_r.act)
		else $error("data stored on terminate edge");
	chk_single_write: assert property (
		wr_ok & wbm & ~full_pg |=> ~wr_r.act)
		else $error("write burst longer than one in single mode");
	chk_read_length: assert property (
		rd_ok |=> rd_r.left == $past(rd_len) - 4'h1)
		else $error("read burst length wrong");
	chk_pre_all_banks: assert property (
		is_pre & ap |=> bank_open == 4'h0)
		else $error("precharge all left a row open");
	chk_closed_refused: assert property (
		is_wr & ~bank_open[ba] |-> ~store | wr_r.act ##1 err_r[sdw_pkg::ERR_CLOSED]
			| err_r[sdw_pkg::ERR_BUSY])
		else $error("access to closed bank not refused");
	chk_page_no_ap: assert property (
		wr_ok & full_pg |=> ~wr_r.ap)
		else $error("auto precharge armed in page mode");
	chk_read_intr_pre: assert property (
		rd_intr |-> pre_go[rd_r.bank] ##1 ~bank_open[$past(rd_r.bank)])
		else $error("interrupted read bank not precharged");
	chk_write_intr_rec: assert property (
		wr_intr |-> rec_go[wr_r.bank] ##[1:4] ~bank_open[$past(wr_r.bank)])
		else $error("interrupted write bank not recovering");
	chk_first_capture: assert property (
		wr_ok |-> store && st_bank == ba && st_col == col)
		else $error("first write element not captured with command");
	cov_bst_write: cover property (wr_r.act & is_bst);
	cov_wr_intr: cover property (wr_intr);
	cov_rd_intr: cover property (rd_intr);
	cov_pre_all: cover property (is_pre & ap & (|bank_open));
endmodule

/* File: dv/sdw_ctl.sv */
// Controller model: drives commands, write data and masks, gathers read data
`timescale 1ns/1ns
module sdw_ctl (
	input wire logic pclk,
	input wire logic [31:0] dq_out,
	input wire logic dq_oe_n,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic bank_select_low,
	output logic bank_select_high,
	output logic [11:0] addr,
	output logic [31:0] dq_in,
	output logic [3:0] dqm
);
	logic [31:0] rq[$]; // Read elements seen
	// Idle command and quiet pins from time zero
	initial cmd(sdw_pkg::SDW_NOP, 2'h0, 12'h000, 32'h0, 4'hf);
	// Capture while the device drives read data
	always @(posedge pclk) if (dq_oe_n === 1'b0) rq.push_back(dq_out);
	// One command edge, launched just after a rising edge
	task automatic cmd(input sdw_pkg::sdw_cmd_t c, input logic [1:0] b, input logic [11:0] a,
			input logic [31:0] d, input logic [3:0] m);
		{cs_n, ras_n, cas_n, we_n} <= c;
		{bank_select_high, bank_select_low} <= b;
		addr <= a;
		dq_in <= d;
		dqm <= m;
		@(posedge pclk);
	endtask
	// Idle edges; released data lines flip so no stale value survives
	task automatic nop(input int n);
		repeat (n) cmd(sdw_pkg::SDW_NOP, 2'h0, 12'h000, ~dq_in, 4'hf);
	endtask
	// Row opened before any access
	task automatic act(input logic [1:0] b);
		cmd(sdw_pkg::SDW_ACT, b, 12'h000, ~dq_in, 4'hf);
		nop(1);
	endtask
	// Burst of n elements, the first one with the command
	task automatic wr(input logic [1:0] b, input logic [11:0] a, input int n, input logic [31:0] d);
		cmd(sdw_pkg::SDW_WR, b, a, d, 4'h0);
		for (int i = 1; i < n; i++) cmd(sdw_pkg::SDW_NOP, b, 12'h000, d + 32'(i), 4'h0);
	endtask
	// Read, then idle past latency and burst; unmasked data tests that it is dropped
	task automatic rd(input logic [1:0] b, input logic [11:0] a);
		cmd(sdw_pkg::SDW_RD, b, a, ~dq_in, 4'h0);
		nop(8);
	endtask
	// Masked recovery edge, PRECHARGE, then the precharge period
	task automatic pre(input logic [1:0] b, input logic all);
		repeat (int'(sdw_pkg::WR_CNT) - 1) cmd(sdw_pkg::SDW_NOP, b, 12'h000, ~dq_in, 4'hf);
		cmd(sdw_pkg::SDW_PRE, b, {1'b0, all, 10'h000}, ~dq_in, 4'hf);
		nop(int'(sdw_pkg::RP_CNT) + 1);
	endtask
endmodule

/* File: dv/sdw_dev_test.sv */
// Self-checking bench for the SDRAM write-termination core
`timescale 1ns/1ns
module sdw_dev_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr, addr;
	logic [31:0] pwdata, prdata, dq_in, dq_out, q;
	logic cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, dq_oe_n;
	logic [3:0] dqm;
	int bad_count = 0;
	int checks_done = 0;
	sdw_dev i_sdw_dev (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .addr(addr),
		.dq_in(dq_in), .dqm(dqm), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
	sdw_ctl i_sdw_ctl (.pclk(pclk), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
		.bank_select_high(bank_select_high), .addr(addr), .dq_in(dq_in), .dqm(dqm));
	// Free-running 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Verdict and end of run
	task automatic finish_test();
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Compare one value
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			finish_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Register read against an expected word
	task automatic rg(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	// Burst read of four elements against a packed expectation
	task automatic rdchk(input logic [1:0] b, input logic [11:0] a, input logic [127:0] x);
		i_sdw_ctl.rq.delete();
		i_sdw_ctl.rd(b, a);
		chk(32'(i_sdw_ctl.rq.size()), 32'h4);
		for (int i = 0; i < 4; i++) chk(i_sdw_ctl.rq[i], x[96-32*i+:32]);
	endtask
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rg(sdw_pkg::MODE_OFF, sdw_pkg::MODE_RST);
		rg(sdw_pkg::STAT_OFF, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, e}, 32'h1);
		// Access to a closed bank is dropped and flagged, flag cleared by one
		i_sdw_ctl.wr(2'h0, 12'h000, 1, 32'h0);
		i_sdw_ctl.nop(1);
		rg(sdw_pkg::ERR_OFF, 32'h1 << sdw_pkg::ERR_CLOSED);
		apb(1'b1, sdw_pkg::ERR_OFF, 32'hf);
		rg(sdw_pkg::ERR_OFF, 32'h0);
		i_sdw_ctl.act(2'h0);
		i_sdw_ctl.act(2'h1);
		rg(sdw_pkg::STAT_OFF, 32'h3);
		// Full bursts back to back fill bank 0 and the first half of bank 1
		i_sdw_ctl.wr(2'h0, 12'h000, 4, 32'h1000);
		i_sdw_ctl.wr(2'h0, 12'h004, 4, 32'h3000);
		i_sdw_ctl.wr(2'h1, 12'h000, 4, 32'h6000);
		// READ cuts a write burst after two elements
		i_sdw_ctl.wr(2'h0, 12'h004, 2, 32'h2000);
		rdchk(2'h0, 12'h004, {32'h2000, 32'h2001, 32'h3002, 32'h3003});
		// Terminate drops the unmasked data on its own edge
		i_sdw_ctl.wr(2'h0, 12'h000, 2, 32'h4000);
		i_sdw_ctl.cmd(sdw_pkg::SDW_BST, 2'h0, 12'h000, 32'hffff, 4'h0);
		rdchk(2'h0, 12'h000, {32'h4000, 32'h4001, 32'h1002, 32'h1003});
		// Single-location writes while reads keep the burst of four
		apb(1'b1, sdw_pkg::MODE_OFF, sdw_pkg::MODE_RST | (32'h1 << sdw_pkg::WBM_BIT));
		i_sdw_ctl.wr(2'h0, 12'h000, 4, 32'h7000);
		rdchk(2'h0, 12'h000, {32'h7000, 32'h4001, 32'h1002, 32'h1003});
		rg(sdw_pkg::WCNT_OFF, 32'h11);
		apb(1'b1, sdw_pkg::MODE_OFF, sdw_pkg::MODE_RST);
		// PRECHARGE cuts a write burst after recovery, masked edges not stored
		i_sdw_ctl.wr(2'h1, 12'h000, 2, 32'h5000);
		i_sdw_ctl.pre(2'h1, 1'b0);
		rg(sdw_pkg::STAT_OFF, 32'h1);
		rg(sdw_pkg::ERR_OFF, 32'h0);
		i_sdw_ctl.act(2'h1);
		rdchk(2'h1, 12'h000, {32'h5000, 32'h5001, 32'h6002, 32'h6003});
		// One bank by its select bits, then all banks with selects ignored
		i_sdw_ctl.act(2'h2);
		i_sdw_ctl.pre(2'h2, 1'b0);
		rg(sdw_pkg::STAT_OFF, 32'h3);
		i_sdw_ctl.pre(2'h3, 1'b1);
		rg(sdw_pkg::STAT_OFF, 32'h0);
		// Auto precharge: bank busy after the burst, then closed
		i_sdw_ctl.act(2'h0);
		i_sdw_ctl.wr(2'h0, 12'h400, 4, 32'h8000);
		i_sdw_ctl.nop(1);
		apb(1'b0, sdw_pkg::STAT_OFF, 32'h0);
		chk({31'h0, q[4]}, 32'h1);
		i_sdw_ctl.nop(8);
		rg(sdw_pkg::STAT_OFF, 32'h0);
		// Continuous page ignores the auto precharge bit
		apb(1'b1, sdw_pkg::MODE_OFF, 32'h0000_0027);
		i_sdw_ctl.act(2'h0);
		i_sdw_ctl.wr(2'h0, 12'h400, 2, 32'h9000);
		i_sdw_ctl.cmd(sdw_pkg::SDW_BST, 2'h0, 12'h000, 32'h0, 4'h0);
		i_sdw_ctl.nop(8);
		rg(sdw_pkg::STAT_OFF, 32'h1);
		apb(1'b1, sdw_pkg::MODE_OFF, sdw_pkg::MODE_RST);
		// Another bank's WRITE cuts an auto precharge write
		i_sdw_ctl.act(2'h2);
		i_sdw_ctl.wr(2'h0, 12'h400, 2, 32'ha000);
		i_sdw_ctl.wr(2'h2, 12'h000, 4, 32'hb000);
		i_sdw_ctl.nop(8);
		rg(sdw_pkg::STAT_OFF, 32'h4);
		i_sdw_ctl.act(2'h0);
		rdchk(2'h0, 12'h000, {32'ha000, 32'ha001, 32'h8002, 32'h8003});
		// Another bank's READ cuts an auto precharge write
		i_sdw_ctl.wr(2'h0, 12'h400, 2, 32'hc000);
		rdchk(2'h2, 12'h000, {32'hb000, 32'hb001, 32'hb002, 32'hb003});
		rg(sdw_pkg::STAT_OFF, 32'h4);
		// Burst of two stores two elements; read back at latency three
		apb(1'b1, sdw_pkg::MODE_OFF, 32'h0000_0031);
		i_sdw_ctl.wr(2'h2, 12'h000, 4, 32'hd000);
		apb(1'b1, sdw_pkg::MODE_OFF, 32'h0000_0032);
		rdchk(2'h2, 12'h000, {32'hd000, 32'hd001, 32'hb002, 32'hb003});
		finish_test();
	end
endmodule
